// [hdl/cij_exec.sv]
// Microsequenced execution of port input, invert, jump and accumulator load instructions.
`default_nettype none
`include "cij_defines.svh"
// Contract
// RULE_01: Opcode fetch takes three cycles, counted in totals.
// RULE_02: Operand fetch reads at pointer, strobes, increments pointer (a jump's operand fetch here skips the increment).
// RULE_03: Direct address goes operand latch, address latch, memory.
// RULE_04: Port read uses port strobe, data to accumulator.
// RULE_05: Indirect port input, seven cycles, pointer plus one.
// RULE_06: Direct invert, nine cycles, pointer plus two.
// RULE_07: Invert accumulator, four cycles.
// RULE_08: Invert pointer register into both registers, five cycles.
// RULE_09: Indirect invert from memory, seven cycles.
// RULE_10: Immediate invert, six cycles, pointer plus two.
// RULE_11: Direct jump loads fetched address, six cycles.
// RULE_12: Register jump copies pointer register, four cycles.
// RULE_13: Jump if not zero direct: six taken, four skipped.
// RULE_14: Register jump if not zero, four cycles.
// RULE_15: Jump if zero direct: six taken, four skipped.
// RULE_16: Register jump if zero, four cycles.
// RULE_17: Direct accumulator load, nine cycles.
// RULE_18: Load accumulator from itself changes nothing else.
// RULE_19: Load accumulator from pointer register, four cycles.
// RULE_20: Direct port input, nine cycles, pointer plus two.
// RULE_21: Zero flag is never written here.
// RULE_22: Memory and ports give data while strobed.
// RULE_23: Instruction pointer wraps modulo 256.
module cij_exec (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic [7:0] i_mem_data,
  input wire logic [7:0] i_port_data,
  input wire logic i_zero_flag,
  input wire logic i_ptr_wr,
  input wire logic [7:0] i_ptr_wdata,
  output cij_pkg::cij_rd_bus_s o_rd_bus,
  output logic [7:0] o_instruction_pointer,
  output logic [7:0] o_acc,
  output logic [7:0] o_ptr,
  output logic o_instr_done,
  output logic o_unknown_op
);
  import cij_pkg::*;

  cij_state_s s_q;
  cij_state_s s_d;
  cij_decode_s dec_now;
  cij_decode_s dec_use;
  logic [7:0] alu_b;
  logic alu_inv;
  logic [7:0] alu_f;

  // Advances the instruction pointer; an 8-bit sum wraps from 8'hFF to 8'h00.
  function automatic logic [7:0] iptr_inc(input logic [7:0] cur);
    iptr_inc = cur + `CIJ_IPTR_STEP;  // RULE_23
  endfunction

  // Tells whether a branch condition holds for the current zero flag.
  function automatic logic cond_met(input cij_cond_e c, input logic z);
    case (c)
      CND_NZ: cond_met = !z;
      CND_Z: cond_met = z;
      default: cond_met = 1'b1;
    endcase
  endfunction

  // Decodes the opcode byte held in the data latch during the last fetch step.
  cij_op_decode u_dec (
    .i_opcode(s_q.data_lat),
    .o_dec(dec_now)
  );

  // The decode is taken live in the last fetch step and from the state afterwards.
  assign dec_use = (s_q.st == ST_F3) ? dec_now : s_q.dec;

  // Register forms feed the function unit from a register, all others from the data latch.
  always_comb begin
    alu_b = s_q.data_lat;
    alu_inv = s_q.dec.invert;
    if (s_q.st == ST_REG) begin
      if (s_q.dec.op == OP_CPL_R) begin
        alu_b = s_q.ptr;
      end else begin
        alu_b = s_q.acc;
      end
    end
  end

  cij_alu u_alu (
    .i_b(alu_b),
    .i_invert(alu_inv),
    .o_f(alu_f)
  );

  // Next-state logic for every micro-step.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.unk = 1'b0;
    // Neighbouring logic may load the pointer register; this slice's own write wins.
    if (i_ptr_wr) begin
      s_d.ptr = i_ptr_wdata;
    end
    case (s_q.st)
      ST_F1: begin
        s_d.addr_lat = s_q.iptr;  // RULE_01
        s_d.mem_rd = 1'b1;
        s_d.port_rd = 1'b0;
        s_d.st = ST_F2;
      end
      ST_F2: begin
        s_d.data_lat = i_mem_data;  // RULE_22
        s_d.iptr = iptr_inc(s_q.iptr);  // RULE_01
        s_d.st = ST_F3;
      end
      ST_F3: begin
        s_d.mem_rd = 1'b0;
        s_d.dec = dec_use;
        s_d.unk = (dec_now.op == OP_UNK);
        // A skipped conditional jump only steps past its operand byte.
        if ((dec_now.oper == OPR_IMM || dec_now.oper == OPR_DIR) &&
            (!dec_now.jump || cond_met(dec_now.cond, i_zero_flag))) begin  // RULE_13 RULE_15 RULE_21
          s_d.st = ST_ADDR_LD;
        end else if (dec_now.oper == OPR_IND) begin
          s_d.st = ST_OR_LD;
        end else begin
          s_d.st = ST_REG;
        end
      end
      ST_ADDR_LD: begin
        s_d.addr_lat = s_q.iptr;  // RULE_02
        s_d.mem_rd = 1'b1;
        s_d.st = ST_ADDR_CAP;
      end
      ST_ADDR_CAP: begin
        s_d.data_lat = i_mem_data;  // RULE_02 RULE_22
        // A jump overwrites the pointer anyway, so it skips the increment.
        if (!s_q.dec.jump) begin
          s_d.iptr = iptr_inc(s_q.iptr);  // RULE_02
        end
        if (s_q.dec.oper == OPR_DIR && !s_q.dec.jump) begin
          s_d.st = ST_OR_LD;
        end else begin
          s_d.mem_rd = 1'b0;
          s_d.st = ST_WB;
        end
      end
      ST_OR_LD: begin
        s_d.mem_rd = 1'b0;
        if (s_q.dec.oper == OPR_IND) begin
          s_d.opl = s_q.ptr;  // RULE_05 RULE_09
        end else begin
          s_d.opl = s_q.data_lat;  // RULE_03
        end
        s_d.st = ST_OP_LD;
      end
      ST_OP_LD: begin
        s_d.addr_lat = s_q.opl;  // RULE_03
        s_d.mem_rd = !s_q.dec.port;  // RULE_04
        s_d.port_rd = s_q.dec.port;  // RULE_04
        s_d.st = ST_OP_CAP;
      end
      ST_OP_CAP: begin
        if (s_q.dec.port) begin
          s_d.data_lat = i_port_data;  // RULE_04 RULE_22
        end else begin
          s_d.data_lat = i_mem_data;  // RULE_03 RULE_22
        end
        s_d.st = ST_WB;
      end
      ST_WB: begin
        s_d.mem_rd = 1'b0;
        s_d.port_rd = 1'b0;
        if (s_q.dec.jump) begin
          s_d.iptr = s_q.data_lat;  // RULE_11 RULE_13 RULE_15
        end else begin
          s_d.acc = alu_f;  // RULE_04 RULE_06 RULE_10 RULE_17 RULE_20
        end
        s_d.done = 1'b1;
        s_d.st = ST_F1;
      end
      ST_REG: begin
        s_d.st = ST_F1;
        s_d.done = 1'b1;
        case (s_q.dec.op)
          OP_CPL_A: s_d.acc = alu_f;  // RULE_07
          OP_CPL_R: begin
            s_d.acc = alu_f;  // RULE_08
            s_d.st = ST_REG2;
            s_d.done = 1'b0;
          end
          OP_JUMP_R, OP_JUMPNZ_R, OP_JUMPZ_R: begin
            if (cond_met(s_q.dec.cond, i_zero_flag)) begin
              s_d.iptr = s_q.ptr;  // RULE_12 RULE_14 RULE_16
            end
          end
          OP_JUMPNZ_DIR, OP_JUMPZ_DIR: s_d.iptr = iptr_inc(s_q.iptr);  // RULE_13 RULE_15
          OP_LOAD_R: s_d.acc = s_q.ptr;  // RULE_19
          default: s_d.st = ST_F1;  // RULE_18
        endcase
      end
      ST_REG2: begin
        s_d.ptr = s_q.acc;  // RULE_08
        s_d.done = 1'b1;
        s_d.st = ST_F1;
      end
      default: s_d.st = ST_F1;
    endcase
  end

  // State register; the enable freezes every bit while low.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
      s_q.iptr <= `CIJ_RST_IPTR;
      s_q.acc <= `CIJ_RST_ACC;
      s_q.ptr <= `CIJ_RST_PTR;
    end else if (i_enable) begin
      s_q <= s_d;
    end
  end

  // Outputs are taken directly from state flip-flops.
  assign o_rd_bus = '{s_q.addr_lat, s_q.mem_rd, s_q.port_rd};
  assign o_instruction_pointer = s_q.iptr;
  assign o_acc = s_q.acc;
  assign o_ptr = s_q.ptr;
  assign o_instr_done = s_q.done;
  assign o_unknown_op = s_q.unk;

  // Checks count only enabled clock edges, so a frozen block does not trip them.
  default clocking cb @(posedge i_clock iff i_enable);
  endclocking
  default disable iff (!i_rst_b);

  // The fetch runs three steps, decoding in the last with the memory strobe still up.
  property p_fetch;
    s_q.st == ST_F1 |=> s_q.st == ST_F2 ##1 s_q.st == ST_F3 && o_rd_bus.mem_rd;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch sequence broken"); // RULE_01

  // Operand fetch outside jumps reads at the pointer and then advances it.
  property p_operand_fetch;
    s_q.st == ST_ADDR_LD && !s_q.dec.jump |=>
      o_rd_bus.addr == $past(s_q.iptr) && o_rd_bus.mem_rd ##1 s_q.iptr == o_rd_bus.addr + 8'h01;
  endproperty
  a_operand_fetch: assert property (p_operand_fetch) else $error("operand fetch wrong"); // RULE_02

  // The direct address byte reaches the bus two steps after its capture.
  property p_direct_addr;
    s_q.st == ST_OR_LD && s_q.dec.oper == OPR_DIR |=> ##1 o_rd_bus.addr == $past(s_q.data_lat, 2);
  endproperty
  a_direct_addr: assert property (p_direct_addr) else $error("direct address not driven"); // RULE_03

  // Port reads never raise the memory strobe, and the two strobes never overlap.
  property p_port_strobe;
    !(o_rd_bus.mem_rd && o_rd_bus.port_rd);
  endproperty
  a_port_strobe: assert property (p_port_strobe) else $error("both read strobes high"); // RULE_04

  // Indirect port input ends five steps after decode with port data in the accumulator.
  property p_in_ind;
    s_q.st == ST_F3 && dec_now.op == OP_IN_IND |-> ##5 s_q.st == ST_F1 && s_q.acc == $past(i_port_data, 2);
  endproperty
  a_in_ind: assert property (p_in_ind) else $error("indirect port input timing"); // RULE_05

  // Direct invert ends seven steps after the decode step.
  property p_cpl_dir;
    s_q.st == ST_F3 && dec_now.op == OP_CPL_DIR |-> ##7 s_q.st == ST_F1 && s_q.acc == ~$past(i_mem_data, 2);
  endproperty
  a_cpl_dir: assert property (p_cpl_dir) else $error("direct invert wrong"); // RULE_06

  // Inverting the pointer register leaves the result in both registers.
  property p_cpl_r;
    s_q.st == ST_F3 && dec_now.op == OP_CPL_R |-> ##3 s_q.st == ST_F1 && s_q.ptr == s_q.acc &&
      s_q.acc == ~$past(s_q.ptr, 2);
  endproperty
  a_cpl_r: assert property (p_cpl_r) else $error("pointer register invert wrong"); // RULE_08

  // A skipped jump if zero steps past the operand in one step.
  property p_jumpz_skip;
    s_q.st == ST_F3 && dec_now.op == OP_JUMPZ_DIR && !i_zero_flag |=>
      s_q.st == ST_REG ##1 s_q.st == ST_F1 && s_q.iptr == $past(s_q.iptr) + 8'h01;
  endproperty
  a_jumpz_skip: assert property (p_jumpz_skip) else $error("skipped jump wrong"); // RULE_15

  // A register jump loads the pointer register value into the instruction pointer.
  property p_jump_r;
    s_q.st == ST_REG && s_q.dec.op == OP_JUMP_R |=> s_q.iptr == $past(s_q.ptr) && s_q.st == ST_F1;
  endproperty
  a_jump_r: assert property (p_jump_r) else $error("register jump wrong"); // RULE_12

  // Loading the accumulator from itself leaves it unchanged.
  property p_load_a;
    s_q.st == ST_REG && s_q.dec.op == OP_LOAD_A |=> $stable(s_q.acc) && $stable(s_q.iptr);
  endproperty
  a_load_a: assert property (p_load_a) else $error("self load changed state"); // RULE_18

  // Inverting the accumulator writes back its complement in one step.
  property p_cpl_a;
    s_q.st == ST_REG && s_q.dec.op == OP_CPL_A |=> s_q.acc == ~$past(s_q.acc) && s_q.st == ST_F1;
  endproperty
  a_cpl_a: assert property (p_cpl_a) else $error("accumulator invert wrong"); // RULE_07

  // Indirect invert ends five steps after decode with the complemented byte.
  property p_cpl_ind;
    s_q.st == ST_F3 && dec_now.op == OP_CPL_IND |-> ##5 s_q.st == ST_F1 && s_q.acc == ~$past(i_mem_data, 2);
  endproperty
  a_cpl_ind: assert property (p_cpl_ind) else $error("indirect invert wrong"); // RULE_09

  // Immediate invert ends four steps after decode, with the pointer past its data byte.
  property p_cpl_imm;
    s_q.st == ST_F3 && dec_now.op == OP_CPL_IMM |-> ##4 s_q.st == ST_F1 &&
      s_q.acc == ~$past(i_mem_data, 2) && s_q.iptr == $past(s_q.iptr, 4) + 8'h01;
  endproperty
  a_cpl_imm: assert property (p_cpl_imm) else $error("immediate invert wrong"); // RULE_10

  // A direct jump loads the fetched address byte four steps after decode.
  property p_jump_dir;
    s_q.st == ST_F3 && dec_now.op == OP_JUMP_DIR |-> ##4 s_q.st == ST_F1 && s_q.iptr == $past(i_mem_data, 2);
  endproperty
  a_jump_dir: assert property (p_jump_dir) else $error("direct jump wrong"); // RULE_11

  // A taken jump if not zero behaves as a direct jump.
  property p_jumpnz_taken;
    s_q.st == ST_F3 && dec_now.op == OP_JUMPNZ_DIR && !i_zero_flag |-> ##4 s_q.st == ST_F1 &&
      s_q.iptr == $past(i_mem_data, 2);
  endproperty
  a_jumpnz_taken: assert property (p_jumpnz_taken) else $error("taken jump wrong"); // RULE_13

  // Register jump if not zero follows the flag seen in its last step.
  property p_jumpnz_r;
    s_q.st == ST_REG && s_q.dec.op == OP_JUMPNZ_R |=>
      s_q.iptr == ($past(i_zero_flag) ? $past(s_q.iptr) : $past(s_q.ptr));
  endproperty
  a_jumpnz_r: assert property (p_jumpnz_r) else $error("register jump if not zero wrong"); // RULE_14

  // Register jump if zero follows the flag seen in its last step.
  property p_jumpz_r;
    s_q.st == ST_REG && s_q.dec.op == OP_JUMPZ_R |=>
      s_q.iptr == ($past(i_zero_flag) ? $past(s_q.ptr) : $past(s_q.iptr));
  endproperty
  a_jumpz_r: assert property (p_jumpz_r) else $error("register jump if zero wrong"); // RULE_16

  // Direct load ends seven steps after decode with the addressed byte.
  property p_load_dir;
    s_q.st == ST_F3 && dec_now.op == OP_LOAD_DIR |-> ##7 s_q.st == ST_F1 && s_q.acc == $past(i_mem_data, 2);
  endproperty
  a_load_dir: assert property (p_load_dir) else $error("direct load wrong"); // RULE_17

  // Direct port input ends seven steps after decode with the port byte.
  property p_in_dir;
    s_q.st == ST_F3 && dec_now.op == OP_IN_DIR |-> ##7 s_q.st == ST_F1 && s_q.acc == $past(i_port_data, 2);
  endproperty
  a_in_dir: assert property (p_in_dir) else $error("direct port input wrong"); // RULE_20

endmodule
`default_nettype wire

// [hdl/cij_defines.svh]
// Opcode encodings, reset values and the instruction pointer step for the execution slice.
`ifndef CIJ_DEFINES_SVH
`define CIJ_DEFINES_SVH

// Opcodes handled by this slice.
`define CIJ_OPC_IN_DIR   8'h08
`define CIJ_OPC_IN_IND   8'h0C
`define CIJ_OPC_CPL_DIR 8'h88
`define CIJ_OPC_CPL_A 8'h8A
`define CIJ_OPC_CPL_R 8'h8B
`define CIJ_OPC_CPL_IND 8'h8C
`define CIJ_OPC_CPL_IMM 8'h8E
`define CIJ_OPC_JUMP_DIR 8'h20
`define CIJ_OPC_JUMP_R 8'h23
`define CIJ_OPC_JUMPNZ_DIR 8'h28
`define CIJ_OPC_JUMPNZ_R 8'h2B
`define CIJ_OPC_JUMPZ_DIR 8'h30
`define CIJ_OPC_JUMPZ_R 8'h33
`define CIJ_OPC_LOAD_DIR 8'h40
`define CIJ_OPC_LOAD_A 8'h42
`define CIJ_OPC_LOAD_R 8'h43

// Register values after reset.
`define CIJ_RST_IPTR 8'h00
`define CIJ_RST_ACC 8'h00
`define CIJ_RST_PTR 8'h00

// Instruction pointer step.
`define CIJ_IPTR_STEP 8'h01

`endif

// [hdl/cij_pkg.sv]
// Types shared by the execution slice: states, decoded ops and carriers.
`default_nettype none
package cij_pkg;

  // Micro-step sequence; the fetch step comes first so a zeroed state is a fetch.
  typedef enum logic [3:0] {
    ST_F1, ST_F2, ST_F3, ST_ADDR_LD, ST_ADDR_CAP, ST_OR_LD,
    ST_OP_LD, ST_OP_CAP, ST_WB, ST_REG, ST_REG2
  } cij_state_e;

  // Instruction identity after decode.
  typedef enum logic [4:0] {
    OP_UNK, OP_IN_DIR, OP_IN_IND, OP_CPL_DIR, OP_CPL_A, OP_CPL_R, OP_CPL_IND,
    OP_CPL_IMM, OP_JUMP_DIR, OP_JUMP_R, OP_JUMPNZ_DIR, OP_JUMPNZ_R, OP_JUMPZ_DIR,
    OP_JUMPZ_R, OP_LOAD_DIR, OP_LOAD_A, OP_LOAD_R
  } cij_op_e;

  // Where the operand byte comes from.
  typedef enum logic [1:0] {OPR_NONE, OPR_IMM, OPR_DIR, OPR_IND} cij_oper_e;

  // Branch condition on the zero flag.
  typedef enum logic [1:0] {CND_ALWAYS, CND_NZ, CND_Z} cij_cond_e;

  // Decoder output.
  typedef struct packed {
    cij_op_e   op;
    cij_oper_e oper;
    logic      port;
    logic      invert;
    logic      jump;
    cij_cond_e cond;
  } cij_decode_s;

  // Read bus towards memory and ports.
  typedef struct packed {
    logic [7:0] addr;
    logic       mem_rd;
    logic       port_rd;
  } cij_rd_bus_s;

  // Whole state of the execution slice.
  typedef struct packed {
    cij_state_e  st;
    cij_decode_s dec;
    logic [7:0] iptr;
    logic [7:0] addr_lat;
    logic [7:0] data_lat;
    logic [7:0]  opl;
    logic [7:0]  acc;
    logic [7:0]  ptr;
    logic        mem_rd;
    logic        port_rd;
    logic        done;
    logic        unk;
  } cij_state_s;

endpackage
`default_nettype wire

// [hdl/cij_alu.sv]
// Complement-or-pass function unit used by the invert and load paths.
`default_nettype none
module cij_alu (
  input wire logic [7:0] i_b,
  input wire logic i_invert,
  output logic [7:0] o_f
);
  // The result is the operand itself or its bitwise complement.
  always_comb begin
    if (i_invert) begin
      o_f = ~i_b;
    end else begin
      o_f = i_b;
    end
  end
endmodule
`default_nettype wire

// [hdl/cij_op_decode.sv]
// Opcode decoder for the port input, invert, jump and accumulator load group.
`default_nettype none
`include "cij_defines.svh"
module cij_op_decode (
  input wire logic [7:0] i_opcode,
  output cij_pkg::cij_decode_s o_dec
);
  import cij_pkg::*;

  // Fields: op, operand source, port access, complement, jump, condition.
  always_comb begin
    case (i_opcode)
      `CIJ_OPC_IN_DIR:  o_dec = '{OP_IN_DIR, OPR_DIR, 1'b1, 1'b0, 1'b0, CND_ALWAYS};  // RULE_20
      `CIJ_OPC_IN_IND:  o_dec = '{OP_IN_IND, OPR_IND, 1'b1, 1'b0, 1'b0, CND_ALWAYS};  // RULE_05
      `CIJ_OPC_CPL_DIR: o_dec = '{OP_CPL_DIR, OPR_DIR, 1'b0, 1'b1, 1'b0, CND_ALWAYS}; // RULE_06
      `CIJ_OPC_CPL_A: o_dec = '{OP_CPL_A, OPR_NONE, 1'b0, 1'b1, 1'b0, CND_ALWAYS}; // RULE_07
      `CIJ_OPC_CPL_R: o_dec = '{OP_CPL_R, OPR_NONE, 1'b0, 1'b1, 1'b0, CND_ALWAYS}; // RULE_08
      `CIJ_OPC_CPL_IND: o_dec = '{OP_CPL_IND, OPR_IND, 1'b0, 1'b1, 1'b0, CND_ALWAYS}; // RULE_09
      `CIJ_OPC_CPL_IMM: o_dec = '{OP_CPL_IMM, OPR_IMM, 1'b0, 1'b1, 1'b0, CND_ALWAYS}; // RULE_10
      `CIJ_OPC_JUMP_DIR: o_dec = '{OP_JUMP_DIR, OPR_DIR, 1'b0, 1'b0, 1'b1, CND_ALWAYS}; // RULE_11
      `CIJ_OPC_JUMP_R: o_dec = '{OP_JUMP_R, OPR_NONE, 1'b0, 1'b0, 1'b1, CND_ALWAYS}; // RULE_12
      `CIJ_OPC_JUMPNZ_DIR: o_dec = '{OP_JUMPNZ_DIR, OPR_DIR, 1'b0, 1'b0, 1'b1, CND_NZ}; // RULE_13
      `CIJ_OPC_JUMPNZ_R: o_dec = '{OP_JUMPNZ_R, OPR_NONE, 1'b0, 1'b0, 1'b1, CND_NZ}; // RULE_14
      `CIJ_OPC_JUMPZ_DIR: o_dec = '{OP_JUMPZ_DIR, OPR_DIR, 1'b0, 1'b0, 1'b1, CND_Z}; // RULE_15
      `CIJ_OPC_JUMPZ_R: o_dec = '{OP_JUMPZ_R, OPR_NONE, 1'b0, 1'b0, 1'b1, CND_Z}; // RULE_16
      `CIJ_OPC_LOAD_DIR: o_dec = '{OP_LOAD_DIR, OPR_DIR, 1'b0, 1'b0, 1'b0, CND_ALWAYS}; // RULE_17
      `CIJ_OPC_LOAD_A: o_dec = '{OP_LOAD_A, OPR_NONE, 1'b0, 1'b0, 1'b0, CND_ALWAYS}; // RULE_18
      `CIJ_OPC_LOAD_R: o_dec = '{OP_LOAD_R, OPR_NONE, 1'b0, 1'b0, 1'b0, CND_ALWAYS}; // RULE_19
      default:          o_dec = '{OP_UNK, OPR_NONE, 1'b0, 1'b0, 1'b0, CND_ALWAYS};
    endcase
  end
endmodule
`default_nettype wire

// [tb/cij_rd_model.sv]
// Behavioural program memory and input port devices that answer the read bus.
`default_nettype none
module cij_rd_model (
  input wire logic i_clock,
  input wire cij_pkg::cij_rd_bus_s i_rd_bus,
  output logic [7:0] o_mem_data,
  output logic [7:0] o_port_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import cij_pkg::*;

  logic [7:0] mem [256];
  logic [7:0] port [256];
  logic [7:0] mem_last;
  logic [7:0] port_last;

  // Unwritten locations read as all ones, so a stray fetch is easy to spot.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'hFF;
      port[i] = 8'hFF;
    end
    mem_last = 8'h00;
    port_last = 8'h00;
  end

  // Remember the last byte handed over on each side.
  always @(posedge i_clock) begin
    if (i_rd_bus.mem_rd) begin
      mem_last <= mem[i_rd_bus.addr];
    end
    if (i_rd_bus.port_rd) begin
      port_last <= port[i_rd_bus.addr];
    end
  end

  // Data is valid only while strobed; otherwise the lines show the inverse of the last byte, never a held value.
  assign o_mem_data = i_rd_bus.mem_rd ? mem[i_rd_bus.addr] : ~mem_last;
  assign o_port_data = i_rd_bus.port_rd ? port[i_rd_bus.addr] : ~port_last;
endmodule
`default_nettype wire

// [tb/cij_exec_tb_top.sv]
// Self-checking bench that runs a small program through the execution slice.
`default_nettype none
module cij_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cij_pkg::*;

  logic i_clock;
  logic i_rst_b;
  logic i_enable;
  logic i_zero_flag;
  logic i_ptr_wr;
  logic [7:0] i_ptr_wdata;
  logic [7:0] mem_data;
  logic [7:0] port_data;
  cij_rd_bus_s rd_bus;
  logic [7:0] iptr;
  logic [7:0] acc;
  logic [7:0] ptr;
  logic done;
  logic unk;
  int unk_cnt;
  int err_total;
  int num_checks;

  cij_exec dut (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_enable(i_enable),
    .i_mem_data(mem_data),
    .i_port_data(port_data),
    .i_zero_flag(i_zero_flag),
    .i_ptr_wr(i_ptr_wr),
    .i_ptr_wdata(i_ptr_wdata),
    .o_rd_bus(rd_bus),
    .o_instruction_pointer(iptr),
    .o_acc(acc),
    .o_ptr(ptr),
    .o_instr_done(done),
    .o_unknown_op(unk)
  );

  // Counts unknown-opcode pulses, each seen once at the edge that ends it.
  always @(posedge i_clock) begin
    if (unk === 1'b1) begin
      unk_cnt++;
    end
  end

  cij_rd_model mdl (
    .i_clock(i_clock),
    .i_rd_bus(rd_bus),
    .o_mem_data(mem_data),
    .o_port_data(port_data)
  );

  // A 100 ns clock period.
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compares one byte of design state.
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a measured cycle count.
  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Places a run of bytes in the program memory.
  task automatic load(input logic [7:0] addr, input logic [7:0] bytes[$]);
    foreach (bytes[i]) begin
      mdl.mem[addr + 8'(i)] = bytes[i];
    end
  endtask

  // Runs one instruction from its first fetch cycle to the next completion pulse.
  // The zero flag and an optional pointer load are set up in the fetch cycle; a stall
  // drops the enable for that many cycles just after the fetch starts.
  task automatic step(input logic zf, input logic wr, input logic [7:0] wv, input int stall,
                      input int cyc, input logic [7:0] eip, input logic [7:0] eacc,
                      input logic [7:0] eptr);
    int n;
    n = 0;
    i_zero_flag = zf;
    i_ptr_wr = wr;
    i_ptr_wdata = wv;
    while (n < 40) begin
      @(posedge i_clock);
      #1;
      n++;
      i_ptr_wr = 1'b0;
      i_enable = !(n <= stall);
      if (done === 1'b1) begin
        break;
      end
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, done, 1'b1);
      close_out();
    end
    if (cyc > 0) begin
      chk_cnt(n - stall, cyc);
    end
    chk_byte(iptr, eip);
    chk_byte(acc, eacc);
    chk_byte(ptr, eptr);
  endtask

  // Program, data bytes and port values, then the instruction sequence with expectations.
  initial begin
    err_total = 0;
    num_checks = 0;
    unk_cnt = 0;
    i_rst_b = 1'b0;
    i_enable = 1'b1;
    i_zero_flag = 1'b0;
    i_ptr_wr = 1'b0;
    i_ptr_wdata = 8'h00;
    @(posedge i_clock);
    load(8'h00, '{8'h42, 8'h08, 8'h10, 8'h88, 8'h80, 8'h8A, 8'h8E, 8'h0F, 8'h40, 8'h81, 8'h42, 8'h0C});
    load(8'h0C, '{8'h43, 8'h42, 8'h8C, 8'h8B, 8'h28, 8'h40, 8'h30, 8'h40, 8'h2B, 8'h33, 8'h28, 8'h20});
    load(8'h20, '{8'h30, 8'h30});
    load(8'h30, '{8'h20, 8'h40});
    load(8'h40, '{8'h42, 8'h2B});
    load(8'h50, '{8'h42, 8'h33});
    load(8'h60, '{8'h42, 8'h23});
    load(8'hFE, '{8'h8E, 8'h00});
    load(8'h80, '{8'h04, 8'h5A});
    mdl.port[8'h10] = 8'h3C;
    mdl.port[8'h77] = 8'hA5;
    repeat (5) @(posedge i_clock);
    #1;
    i_rst_b = 1'b1;
    step(1'b0, 1'b0, 8'h00, 0, 4, 8'h01, 8'h00, 8'h00);
    step(1'b0, 1'b0, 8'h00, 0, 9, 8'h03, 8'h3C, 8'h00);
    step(1'b0, 1'b0, 8'h00, 0, 9, 8'h05, 8'hFB, 8'h00);
    step(1'b0, 1'b0, 8'h00, 0, 4, 8'h06, 8'h04, 8'h00);
    step(1'b0, 1'b0, 8'h00, 0, 6, 8'h08, 8'hF0, 8'h00);
    step(1'b0, 1'b0, 8'h00, 0, 9, 8'h0A, 8'h5A, 8'h00);
    step(1'b0, 1'b1, 8'h77, 0, 4, 8'h0B, 8'h5A, 8'h77);
    step(1'b0, 1'b0, 8'h00, 0, 7, 8'h0C, 8'hA5, 8'h77);
    step(1'b0, 1'b0, 8'h00, 0, 4, 8'h0D, 8'h77, 8'h77);
    step(1'b0, 1'b1, 8'h80, 0, 4, 8'h0E, 8'h77, 8'h80);
    step(1'b0, 1'b0, 8'h00, 0, 7, 8'h0F, 8'hFB, 8'h80);
    step(1'b0, 1'b0, 8'h00, 0, 5, 8'h10, 8'h7F, 8'h7F);
    step(1'b1, 1'b0, 8'h00, 0, 4, 8'h12, 8'h7F, 8'h7F);
    step(1'b0, 1'b0, 8'h00, 0, 4, 8'h14, 8'h7F, 8'h7F);
    step(1'b1, 1'b0, 8'h00, 0, 4, 8'h15, 8'h7F, 8'h7F);
    step(1'b0, 1'b0, 8'h00, 0, 4, 8'h16, 8'h7F, 8'h7F);
    step(1'b0, 1'b0, 8'h00, 0, 6, 8'h20, 8'h7F, 8'h7F);
    step(1'b1, 1'b0, 8'h00, 0, 6, 8'h30, 8'h7F, 8'h7F);
    step(1'b0, 1'b0, 8'h00, 0, 6, 8'h40, 8'h7F, 8'h7F);
    step(1'b0, 1'b1, 8'h50, 0, 4, 8'h41, 8'h7F, 8'h50);
    step(1'b0, 1'b0, 8'h00, 0, 4, 8'h50, 8'h7F, 8'h50);
    step(1'b1, 1'b1, 8'h60, 0, 4, 8'h51, 8'h7F, 8'h60);
    step(1'b1, 1'b0, 8'h00, 0, 4, 8'h60, 8'h7F, 8'h60);
    step(1'b0, 1'b1, 8'hFE, 0, 4, 8'h61, 8'h7F, 8'hFE);
    step(1'b0, 1'b0, 8'h00, 0, 4, 8'hFE, 8'h7F, 8'hFE);
    step(1'b0, 1'b0, 8'h00, 3, 6, 8'h00, 8'hFF, 8'hFE);
    mdl.mem[8'h00] = 8'hC5;
    step(1'b0, 1'b0, 8'h00, 0, 4, 8'h01, 8'hFF, 8'hFE);
    chk_cnt(unk_cnt, 1);
    close_out();
  end
endmodule
`default_nettype wire
